// ### rtl/two_wire_target.sv
// Two-wire bus target: byte framing, address match, acknowledge
`timescale 1ns/1ps
module two_wire_target
  import expander_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       reset_n,    // Synchronous reset, active low
  input  wire logic       scl_in,     // Bus clock line level
  input  wire logic       sda_in,     // Bus data line level
  input  wire logic [6:0] dev_addr,   // Own bus address
  input  wire logic [7:0] rd_data,    // Byte to send on the next read
  output logic            sda_out,    // Data line drive value (always low)
  output logic            sda_oe,     // High while pulling data line low
  output logic            start_seen, // Pulse on start or repeated start
  output logic            wr_valid,   // Pulse with a received data byte
  output logic [7:0]      wr_data,    // Received data byte
  output logic            rd_req      // Pulse when rd_data is taken
);

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    link_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  sr;
    logic        rw;
    logic        nack;
    logic        sda_oe;
    logic        start_p;
    logic        wr_p;
    logic        rd_p;
  } link_t;

  link_t s_q, s_d;
  logic  scl_rise, scl_fall, bus_start, bus_stop;

  // Edges and bus conditions from the second synchroniser stage only
  assign scl_rise  = s_q.scl_sync[1] & ~s_q.scl_prev;
  assign scl_fall  = ~s_q.scl_sync[1] & s_q.scl_prev;
  assign bus_start = s_q.scl_sync[1] & s_q.scl_prev &
                     ~s_q.sda_sync[1] & s_q.sda_prev;
  assign bus_stop  = s_q.scl_sync[1] & s_q.scl_prev &
                     s_q.sda_sync[1] & ~s_q.sda_prev;

  // Next-state logic; the target never starts a transfer itself
  always_comb begin
    s_d          = s_q;
    s_d.scl_sync = {s_q.scl_sync[0], scl_in};
    s_d.sda_sync = {s_q.sda_sync[0], sda_in};
    s_d.scl_prev = s_q.scl_sync[1];
    s_d.sda_prev = s_q.sda_sync[1];
    s_d.start_p  = 1'b0;
    s_d.wr_p     = 1'b0;
    s_d.rd_p     = 1'b0;
    if (bus_start) begin
      s_d.st      = LINK_ADDR;
      s_d.cnt     = 4'h0;
      s_d.sda_oe  = 1'b0;
      s_d.start_p = 1'b1;
    end else if (bus_stop) begin
      s_d.st     = LINK_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      unique case (s_q.st)
        LINK_IDLE: begin
          s_d.sda_oe = 1'b0;
        end
        LINK_ADDR, LINK_WRITE: begin
          if (scl_rise) begin
            s_d.sr  = {s_q.sr[6:0], s_q.sda_sync[1]};
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (scl_fall && s_q.cnt == 4'h8) begin
            if (s_q.st == LINK_WRITE) begin
              s_d.sda_oe = 1'b1;
              s_d.wr_p   = 1'b1;
              s_d.st     = LINK_ACK_WRITE;
            end else if (s_q.sr[7:1] == dev_addr) begin
              s_d.sda_oe = 1'b1;
              s_d.rw     = s_q.sr[0];
              s_d.st     = LINK_ACK_ADDR;
            end else begin
              s_d.st = LINK_IDLE;
            end
          end
        end
        LINK_ACK_ADDR, LINK_READ_ACK: begin
          if (scl_rise) begin
            s_d.nack = s_q.sda_sync[1];
          end else if (scl_fall) begin
            s_d.cnt = 4'h0;
            if (s_q.st == LINK_READ_ACK && s_q.nack) begin
              s_d.sda_oe = 1'b0;
              s_d.st     = LINK_IDLE;
            end else if (s_q.st == LINK_READ_ACK || s_q.rw) begin
              s_d.sr     = rd_data;
              s_d.sda_oe = ~rd_data[7];
              s_d.rd_p   = 1'b1;
              s_d.st     = LINK_READ;
            end else begin
              s_d.sda_oe = 1'b0;
              s_d.st     = LINK_WRITE;
            end
          end
        end
        LINK_ACK_WRITE: begin
          if (scl_fall) begin
            s_d.sda_oe = 1'b0;
            s_d.cnt    = 4'h0;
            s_d.st     = LINK_WRITE;
          end
        end
        LINK_READ: begin
          if (scl_fall) begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.cnt == 4'h7) begin
              s_d.sda_oe = 1'b0;
              s_d.st     = LINK_READ_ACK;
            end else begin
              s_d.sr     = {s_q.sr[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sr[6];
            end
          end
        end
        default: begin
          s_d.st     = LINK_IDLE;
          s_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register; reset puts the bus side back to idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1,
               sda_prev: 1'b1, st: LINK_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign sda_out    = 1'b0;
  assign sda_oe     = s_q.sda_oe;
  assign start_seen = s_q.start_p;
  assign wr_valid   = s_q.wr_p;
  assign wr_data    = s_q.sr;
  assign rd_req     = s_q.rd_p;

endmodule // two_wire_target

// ### common/expander_pkg.sv
// Constants and types shared by the I/O expander design
package expander_pkg;

  // Pin count and bank layout
  localparam int unsigned PIN_COUNT  = 24;
  localparam int unsigned BANK_WIDTH = 8;

  // Upper six address bits; the address-select pin supplies bit 0
  localparam logic [5:0] TARGET_ADDR_HI = 6'h11;

  // Command byte fields: auto-increment flag, register kind, bank
  localparam int unsigned CMD_AUTOINC_BIT = 7;
  localparam int unsigned CMD_KIND_LSB    = 2;
  localparam int unsigned CMD_BANK_LSB    = 0;

  // Register kinds and the last bank code carried in the command byte
  localparam logic [1:0] KIND_INPUT    = 2'h0;
  localparam logic [1:0] KIND_OUTPUT   = 2'h1;
  localparam logic [1:0] KIND_POLARITY = 2'h2;
  localparam logic [1:0] KIND_CONFIG   = 2'h3;
  localparam logic [1:0] BANK_LAST     = 2'h2;

  // Register reset values
  localparam logic [23:0] RST_OUTPUT   = 24'hff_ffff;
  localparam logic [23:0] RST_POLARITY = 24'h00_0000;
  localparam logic [23:0] RST_CONFIG   = 24'hff_ffff;
  localparam logic [23:0] RST_INPUT    = 24'h00_0000;
  localparam logic [7:0]  RST_CMD      = 8'h00;

  // Two-wire target states
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ACK_ADDR,
    LINK_WRITE,
    LINK_ACK_WRITE,
    LINK_READ,
    LINK_READ_ACK
  } link_state_t;

endpackage

// ### rtl/io_expander.sv
// 24-pin I/O expander: register banks, pin drive, change interrupt
`timescale 1ns/1ps

// How it works
// - Four 24-bit register sets, each as three 8-bit banks, one bit per pin.
// - After reset every pin is an input with its driver switched off.
// - Each pin is driven when its configuration bit is 0, released at 1.
// - Input bits hold sampled pin levels; outputs follow output bits.
// - A set polarity bit makes the input bit read back inverted.
// - All four register sets can be read back over the bus.
// - Holding reset_n low restores defaults and idles the bus logic.
// - Interrupt is asserted while any input pin differs from its input bit.
// - The interrupt runs on its own, needing no bus polling.
// - The device is only a bus target and never starts a transfer.
// - The address-select pin picks one of two bus addresses.
module io_expander
  import expander_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT // Port pin count
)(
  input  wire logic            clk,       // 25 MHz system clock
  input  wire logic            reset_n,   // Synchronous reset, active low
  input  wire logic            scl_in,    // Bus clock line level
  input  wire logic            sda_in,    // Bus data line level
  output logic                 sda_out,   // Data line drive value
  output logic                 sda_oe,    // High while pulling data low
  input  wire logic            addr_sel,  // Address-select pin level
  input  wire logic [PINS-1:0] port_in,   // Port pin levels
  output logic      [PINS-1:0] port_out,  // Port pin drive values
  output logic      [PINS-1:0] port_oe,   // High while a pin is driven
  output logic                 int_out,   // Interrupt line drive value
  output logic                 int_oe     // High while pulling irq low
);

  typedef struct packed {
    logic [PINS-1:0] sync1;    // First synchroniser stage
    logic [PINS-1:0] sync2;    // Second synchroniser stage
    logic [PINS-1:0] in_reg;   // Captured pin levels
    logic [PINS-1:0] out_reg;  // Output register
    logic [PINS-1:0] pol_reg;  // Polarity inversion register
    logic [PINS-1:0] cfg_reg;  // Configuration, 1 = input
    logic [PINS-1:0] drive;    // Registered pin enables
    logic [7:0]      cmd;      // Command byte / register pointer
    logic            first;    // Next written byte is a command
    logic            irq;      // Registered interrupt drive
  } regs_t;

  regs_t       s_q, s_d;
  logic [6:0]  dev_addr;
  logic [7:0]  rd_data;
  logic        start_seen;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        rd_req;
  logic [1:0]  cmd_kind;
  logic [1:0]  cmd_bank;
  logic [PINS-1:0] reported;
  logic [PINS-1:0] diff;

  // Bus address from the fixed upper bits and the select pin
  assign dev_addr = {TARGET_ADDR_HI, addr_sel};

  // Command byte fields
  assign cmd_kind = s_q.cmd[CMD_KIND_LSB +: 2];
  assign cmd_bank = s_q.cmd[CMD_BANK_LSB +: 2];

  // Input bank reads report the synchronised pins through the polarity
  // register; the pin levels are captured into the input register on
  // rd_req, one clock after the byte is taken, so the two can differ
  assign reported = s_q.sync2 ^ s_q.pol_reg;

  // Change detect on synchronised levels of input pins only
  assign diff = (s_q.sync2 ^ s_q.in_reg) & s_q.cfg_reg;

  // Read data mux; bank codes above the last read as zero
  always_comb begin
    rd_data = 8'h00;
    if (cmd_bank <= BANK_LAST) begin
      unique case (cmd_kind)
        KIND_INPUT:    rd_data = reported[cmd_bank*BANK_WIDTH +: 8];
        KIND_OUTPUT:   rd_data = s_q.out_reg[cmd_bank*BANK_WIDTH +: 8];
        KIND_POLARITY: rd_data = s_q.pol_reg[cmd_bank*BANK_WIDTH +: 8];
        KIND_CONFIG:   rd_data = s_q.cfg_reg[cmd_bank*BANK_WIDTH +: 8];
      endcase
    end
  end

  // Bus target: the device only answers transfers it is addressed in
  two_wire_target u_link (
    .clk        (clk),
    .reset_n    (reset_n),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .dev_addr   (dev_addr),
    .rd_data    (rd_data),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .start_seen (start_seen),
    .wr_valid   (wr_valid),
    .wr_data    (wr_data),
    .rd_req     (rd_req)
  );

  // Register next state
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = port_in;
    s_d.sync2 = s_q.sync1;
    if (start_seen) begin
      s_d.first = 1'b1;
    end
    // Write: first byte sets the pointer, later bytes load a bank
    if (wr_valid) begin
      if (s_q.first) begin
        s_d.cmd   = wr_data;
        s_d.first = 1'b0;
      end else if (cmd_bank <= BANK_LAST) begin
        unique case (cmd_kind)
          KIND_INPUT: ;
          KIND_OUTPUT:
            s_d.out_reg[cmd_bank*BANK_WIDTH +: 8] = wr_data;
          KIND_POLARITY:
            s_d.pol_reg[cmd_bank*BANK_WIDTH +: 8] = wr_data;
          KIND_CONFIG:
            s_d.cfg_reg[cmd_bank*BANK_WIDTH +: 8] = wr_data;
        endcase
      end
    end
    // Read of an input bank refreshes it from the pins
    if (rd_req && cmd_kind == KIND_INPUT && cmd_bank <= BANK_LAST) begin
      s_d.in_reg[cmd_bank*BANK_WIDTH +: 8] =
        s_q.sync2[cmd_bank*BANK_WIDTH +: 8];
    end
    // Pointer steps through the banks of one kind when enabled
    if (((wr_valid && !s_q.first) || rd_req) &&
        s_q.cmd[CMD_AUTOINC_BIT]) begin
      s_d.cmd[CMD_BANK_LSB +: 2] = (cmd_bank >= BANK_LAST) ? 2'h0 :
                                   cmd_bank + 2'h1;
    end
    // Pin enables derive from the settled registers, the interrupt from the current ones
    s_d.drive = ~s_d.cfg_reg;
    s_d.irq   = |diff;
  end

  // State register and reset defaults
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{sync1:   '0,
               sync2:   '0,
               in_reg:  RST_INPUT,
               out_reg: RST_OUTPUT,
               pol_reg: RST_POLARITY,
               cfg_reg: RST_CONFIG,
               drive:   '0,
               cmd:     RST_CMD,
               first:   1'b1,
               irq:     1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from registers
  assign port_out = s_q.out_reg;
  assign port_oe  = s_q.drive;
  assign int_out  = 1'b0;
  assign int_oe   = s_q.irq;

endmodule // io_expander

// ### verif/io_expander_monitor.sv
// Port checker for the I/O expander, bound to its top module
`timescale 1ns/1ps
module io_expander_monitor
  import expander_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT // Port pin count
)(
  input wire logic            clk,      // Clock
  input wire logic            reset_n,  // Reset, active low
  input wire logic            scl_in,   // Bus clock level
  input wire logic            sda_in,   // Bus data level
  input wire logic            sda_out,  // Data drive value
  input wire logic            sda_oe,   // Data pull enable
  input wire logic            addr_sel, // Address pin
  input wire logic [PINS-1:0] port_in,  // Pin levels
  input wire logic [PINS-1:0] port_out, // Pin drive values
  input wire logic [PINS-1:0] port_oe,  // Pin drive enables
  input wire logic            int_out,  // Irq drive value
  input wire logic            int_oe    // Irq pull enable
);
  // Rising edge throughout; quiet in reset unless a property says
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // An input pin moves while the bus is idle and nothing is pending
  sequence s_pin_move;
    $changed(port_in & ~port_oe) && $stable(port_oe) && !int_oe
      && scl_in && sda_in;
  endsequence
  property p_rst_pins;
    disable iff (1'b0) !reset_n |=> port_oe == '0 && port_out == RST_OUTPUT;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins not reset");
  property p_rst_bus;
    disable iff (1'b0) !reset_n |=> !sda_oe && !int_oe;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus not idle");
  property p_drive_low;
    sda_out == 1'b0 && int_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive high");
  property p_sda_hold;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
  property p_sda_rise;
    $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_sda_rise: assert property (p_sda_rise) else $error("sda early");
  property p_out_write;
    $changed(port_out) && $past(reset_n) |-> sda_oe;
  endproperty
  a_out_write: assert property (p_out_write) else $error("out moved");
  property p_cfg_write;
    $changed(port_oe) && $past(reset_n) |-> sda_oe;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("oe moved");
  property p_int_raise;
    s_pin_move |-> ##[1:6] int_oe;
  endproperty
  a_int_raise: assert property (p_int_raise) else $error("no irq");
  property p_int_hold;
    int_oe && scl_in && sda_in && port_in == $past(port_in, 6)
      && $stable(port_oe) |=> int_oe;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("irq lost");
endmodule // io_expander_monitor

bind io_expander io_expander_monitor #(.PINS(PINS)) mon_u (.clk(clk),
  .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_sel(addr_sel), .port_in(port_in),
  .port_out(port_out), .port_oe(port_oe), .int_out(int_out),
  .int_oe(int_oe));

// ### verif/bus_host_model.sv
// Two-wire bus controller model facing the expander
`timescale 1ns/1ps
module bus_host_model (
  input  wire logic clk,     // System clock
  input  wire logic sda_in,  // Data wire level
  output logic      scl,     // Clock wire level, idle high
  output logic      sda_low  // High while pulling data low
);
  // Bus starts released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // A third of a bus bit, long enough for the target's synchronisers
  task automatic gap();
    repeat (8) @(negedge clk);
  endtask
  // Start or repeated start; only the host opens transfers
  task automatic start();
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b1;
    gap();
    scl = 1'b0;
    gap();
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b0;
    gap();
  endtask
  // Eight bits MSB first and the acknowledge slot, data moved in low phase
  task automatic byte_io(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !w[i];
      gap();
      scl = 1'b1;
      gap();
      r[i] = sda_in;
      scl = 1'b0;
      gap();
    end
  endtask
endmodule // bus_host_model

// ### verif/tb_io_expander.sv
// Self-checking bench for the I/O expander
`timescale 1ns/1ps
module tb_io_expander;
  import expander_pkg::*;
  logic        clk, reset_n, addr_sel, scl, sda_low, sda_out, sda_oe;
  logic        int_out, int_oe, ok;
  logic [8:0]  r;
  logic [23:0] ext_in, port_out, port_oe, got;
  logic [23:0] m [4];
  wire  [23:0] port_in;
  wire         sda_w;
  int          num_errors, num_checks;

  // Pins follow the expander where driven, else the outside world
  assign port_in = (port_out & port_oe) | (ext_in & ~port_oe);
  // Data wire with pull-up
  assign sda_w = !(sda_low || (sda_oe && !sda_out));

  io_expander #(.PINS(24)) dut_u (.clk(clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .int_out(int_out), .int_oe(int_oe));
  bus_host_model host_u (.clk(clk), .sda_in(sda_w), .scl(scl),
    .sda_low(sda_low));

  // Clock and watchdog
  initial clk = 1'b0;
  always #20 clk = ~clk;
  initial begin
    #3600000;
    num_errors++;
    summarize();
  end

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Start plus address byte; ok is set when the target acknowledges
  task automatic addr_ph(input logic [6:0] a, input logic rd);
    host_u.start();
    host_u.byte_io({a, rd, 1'b1}, r);
    ok = !r[0];
  endtask
  // Auto-increment access of all three banks of one register kind
  task automatic rw3(input logic rd, input logic [1:0] k,
                     inout logic [23:0] v);
    addr_ph({TARGET_ADDR_HI, addr_sel}, 1'b0);
    host_u.byte_io({1'b1, 3'h0, k, 2'h0, 1'b1}, r);
    if (rd) addr_ph({TARGET_ADDR_HI, addr_sel}, 1'b1);
    for (int b = 0; b < 3; b++) begin
      host_u.byte_io(rd ? {8'hff, b == 2} : {v[8*b +: 8], 1'b1}, r);
      if (rd) v[8*b +: 8] = r[8:1];
    end
    host_u.stop();
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hdb4c));
    reset_n = 1'b0;
    addr_sel = 1'b0;
    num_errors = 0;
    num_checks = 0;
    ext_in = 24'($urandom);
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk("port_oe", '0, port_oe);
    chk("port_out", RST_OUTPUT, port_out);
    chk("bus_irq", '0, {sda_oe, int_oe});
    m = '{RST_INPUT, RST_OUTPUT, RST_POLARITY, RST_CONFIG};
    repeat (8) @(negedge clk);
    for (int n = 0; n < 3; n++) begin
      for (int k = 1; k < 4; k++) begin
        rw3(1'b1, 2'(k), got);
        chk("reg", m[k], got);
        m[k] = 24'($urandom);
        m[3][0] = 1'b1;
        rw3(1'b0, 2'(k), m[k]);
      end
      chk("port_oe", ~m[3], port_oe);
      chk("port_out", m[1], port_out);
      rw3(1'b1, KIND_INPUT, got);
      chk("input", ((m[1] & ~m[3]) | (ext_in & m[3])) ^ m[2], got);
      chk("irq", '0, int_oe);
      for (int t = 0; t < 3; t++) begin
        ext_in[0] = !ext_in[0];
        repeat (10) @(negedge clk);
        chk("irq", 24'(t != 1), int_oe);
      end
      rw3(1'b1, KIND_INPUT, got);
      chk("irq", '0, int_oe);
    end
    for (int s = 0; s < 2; s++) begin
      addr_sel = s[0];
      addr_ph({TARGET_ADDR_HI, !s[0]}, 1'b0);
      host_u.stop();
      chk("nack", '0, ok);
      addr_ph({TARGET_ADDR_HI, s[0]}, 1'b0);
      chk("ack", 24'h1, ok);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      chk("port_oe", '0, port_oe);
      host_u.stop();
      rw3(1'b1, KIND_CONFIG, got);
      chk("config", RST_CONFIG, got);
    end
    summarize();
  end
endmodule // tb_io_expander
